// ---- verif/reset_and_wake_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module reset_and_wake_control_tb;
  import rwc_pkg::*;
  // design pins
  logic              aclk, aresetn, hw_reset_in_n, wake_event_in;
  logic              chip_sel_low, write_strobe_low, read_strobe_low;
  logic              host_write_ok, host_read_seen, power_saving, irq;
  logic              wake_indicator_o, wake_indicator_oe;
  logic              s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic              s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [AXI_AW-1:0] s_awaddr, s_araddr;
  logic [AXI_DW-1:0] s_wdata, s_rdata;
  logic [AXI_SW-1:0] s_wstrb;
  logic [1:0]        s_bresp, s_rresp;
  // bench state
  int                n_mismatch, compares, n_ok, n_rd, tn, i, k;
  logic [31:0]       seed, m;
  logic [2:0]        cfg;

  rwc_reset_wake u_rwc_reset_wake (.*);
  rwc_host_model u_rwc_host_model (.*);

  always #2.5 aclk = ~aclk;

  // count accepted host writes
  always @(posedge aclk) if (host_write_ok === 1'b1) n_ok <= n_ok + 1;

  // count host read cycle starts, one per cycle however long
  always @(posedge aclk) if (host_read_seen === 1'b1) n_rd <= n_rd + 1;

  // expected {oe, o}: c[0] enable, c[1] active high, c[2] push-pull
  function automatic logic [1:0] exp_pin(input logic [2:0] c,
                                         input logic act);
    logic o;
    o = (act && c[0]) ? c[1] : !c[1];
    return {c[2] | !o, o};
  endfunction : exp_pin

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // one register access; d is write data or expected read data
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] er);
    int t;
    @(posedge aclk);
    s_awaddr <= a;
    s_araddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= {3{w}};
    {s_arvalid, s_rready} <= {2{!w}};
    for (t = 0; t < 64; t++) begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_arready) s_arvalid <= 1'b0;
      if (s_bvalid || s_rvalid) break;
    end
    if (t == 64) begin
      n_mismatch++;
      stop_test;
    end
    chk(w ? s_bresp : s_rresp, er);
    if (!w) chk(s_rdata, d);
    {s_bready, s_rready} <= 2'b00;
    @(posedge aclk);
  endtask : bus

  // one-cycle wake event
  task automatic ev;
    @(posedge aclk);
    wake_event_in <= 1'b1;
    @(posedge aclk);
    wake_event_in <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : ev

  task automatic done;
    tn++;
    $display("test %0d finished", tn);
  endtask : done

  // watchdog
  initial begin
    repeat (50000) @(posedge aclk);
    n_mismatch++;
    stop_test;
  end

  initial begin
    seed = 32'h2942115a;
    {aclk, aresetn, wake_event_in, s_awvalid, s_wvalid} = '0;
    {s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    {hw_reset_in_n, s_wstrb} = '1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({power_saving, irq, wake_indicator_oe, wake_indicator_o}, 1);
    bus(0, REG_STATE, 32'h1, RESP_OKAY);
    bus(0, REG_CTRL, 32'h0, RESP_OKAY);
    bus(0, REG_EVT_STAT, 32'h0, RESP_OKAY);
    bus(0, 8'h10, 32'h0, RESP_SLVERR);
    // unmapped write refused, status write ignored, byte 0 strobe needed
    bus(1, 8'h10, 32'h1c, RESP_SLVERR);
    bus(1, REG_STATE, 32'h4, RESP_OKAY);
    s_wstrb <= '0;
    bus(1, REG_CTRL, 32'h1c, RESP_OKAY);
    s_wstrb <= '1;
    bus(0, REG_CTRL, 32'h0, RESP_OKAY);
    bus(0, REG_STATE, 32'h1, RESP_OKAY);
    done;
    // write before the first read is refused
    u_rwc_host_model.cycle(1'b1, 2);
    chk(n_ok, 0);
    bus(0, REG_EVT_STAT, 32'h4, RESP_OKAY);
    u_rwc_host_model.cycle(1'b0, 1);
    chk(n_rd, 1);
    u_rwc_host_model.cycle(1'b1, 3);
    chk(n_ok, 1);
    bus(1, REG_EVT_STAT, 32'h7, RESP_OKAY);
    done;
    // every enable, polarity and driver setting, random mask
    for (i = 0; i < 8; i++) begin
      cfg = i[2:0];
      m = $random(seed) & 32'h7;
      bus(1, REG_CTRL, {27'h0, cfg, 2'h0}, RESP_OKAY);
      bus(1, REG_EVT_MASK, m, RESP_OKAY);
      bus(0, REG_EVT_MASK, m, RESP_OKAY);
      ev;
      chk({wake_indicator_oe, wake_indicator_o}, exp_pin(cfg, 1));
      chk(irq, m[0]);
      bus(1, REG_EVT_STAT, 32'h1, RESP_OKAY);
      chk({wake_indicator_oe, wake_indicator_o}, exp_pin(cfg, 0));
      chk(irq, 1'b0);
    end
    // a wake event landing with its own clear keeps the status bit
    fork
      bus(1, REG_EVT_STAT, 32'h1, RESP_OKAY);
      begin
        repeat (2) @(posedge aclk);
        wake_event_in <= 1'b1;
        @(posedge aclk);
        wake_event_in <= 1'b0;
      end
    join
    bus(0, REG_EVT_STAT, 32'h1, RESP_OKAY);
    bus(1, REG_EVT_STAT, 32'h1, RESP_OKAY);
    done;
    // event and read keep the sleep, any write ends it
    for (k = 0; k < 3; k++) begin
      bus(1, REG_CTRL, 32'h5, RESP_OKAY);
      chk(power_saving, 1'b1);
      ev;
      u_rwc_host_model.cycle(1'b0, 2);
      chk({power_saving, wake_indicator_oe, wake_indicator_o}, 6);
      i = n_ok;
      u_rwc_host_model.cycle(1'b1, 1 + ($random(seed) & 3));
      chk(power_saving, 1'b0);
      chk(n_ok, i);
      bus(0, REG_STATE, 32'h1, RESP_OKAY);
      bus(0, REG_EVT_STAT, 32'h3, RESP_OKAY);
      bus(1, REG_EVT_STAT, 32'h3, RESP_OKAY);
      u_rwc_host_model.cycle(1'b0, 1);
    end
    // two reads per round, each counted once, asleep or not
    chk(n_rd, 7);
    done;
    // soft reset clears registers and demands a read
    bus(1, REG_EVT_MASK, 32'h7, RESP_OKAY);
    bus(1, REG_CTRL, 32'h1e, RESP_OKAY);
    repeat (6) @(posedge aclk);
    bus(0, REG_CTRL, 32'h0, RESP_OKAY);
    bus(0, REG_EVT_MASK, 32'h0, RESP_OKAY);
    bus(0, REG_STATE, 32'h1, RESP_OKAY);
    done;
    // reset pin acts at once, mid-run
    u_rwc_host_model.cycle(1'b0, 1);
    bus(1, REG_CTRL, 32'h1c, RESP_OKAY);
    bus(1, REG_EVT_MASK, 32'h1, RESP_OKAY);
    ev;
    chk({irq, wake_indicator_oe, wake_indicator_o}, 7);
    hw_reset_in_n <= 1'b0;
    #1;
    chk({irq, wake_indicator_oe, wake_indicator_o}, 1);
    repeat (3) @(posedge aclk);
    hw_reset_in_n <= 1'b1;
    repeat (4) @(posedge aclk);
    bus(0, REG_CTRL, 32'h0, RESP_OKAY);
    bus(0, REG_STATE, 32'h1, RESP_OKAY);
    done;
    stop_test;
  end
endmodule : reset_and_wake_control_tb

`default_nettype wire

// ---- verif/rwc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module rwc_host_model (
  // clock
  input wire logic aclk,
  // host strobes, idle high
  output logic     chip_sel_low,
  output logic     write_strobe_low,
  output logic     read_strobe_low
);
  // bus idle until the first cycle
  initial begin
    chip_sel_low = 1'b1;
    write_strobe_low = 1'b1;
    read_strobe_low = 1'b1;
  end

  // one host cycle held len clocks; a waking write needs no particular
  // register, the address is not modelled
  task automatic cycle(input logic wr, input int len);
    @(posedge aclk);
    chip_sel_low <= 1'b0;
    write_strobe_low <= !wr;
    read_strobe_low <= wr;
    repeat (len) @(posedge aclk);
    chip_sel_low <= 1'b1;
    write_strobe_low <= 1'b1;
    read_strobe_low <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : cycle
endmodule : rwc_host_model

`default_nettype wire

// ---- verif/rwc_reset_wake_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module rwc_reset_wake_monitor
  import rwc_pkg::*;
(
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hw_reset_in_n,
  // host strobes and results
  input wire logic chip_sel_low,
  input wire logic write_strobe_low,
  input wire logic host_write_ok,
  input wire logic host_read_seen,
  input wire logic power_saving,
  // wake pin and interrupt
  input wire logic wake_indicator_o,
  input wire logic wake_indicator_oe,
  input wire logic irq,
  // bus handshakes
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid
);
  logic wr_q;     // write level one cycle back
  logic rd_seen;  // host read since reset or wake
  wire  wr_start = !chip_sel_low && !write_strobe_low && !wr_q;

  // write history and read-since-wake tracking
  always_ff @(posedge aclk) begin
    wr_q <= !chip_sel_low && !write_strobe_low;
    if (!aresetn || !hw_reset_in_n) rd_seen <= 1'b0;
    else if (power_saving && wr_start) rd_seen <= 1'b0;
    else if (host_read_seen) rd_seen <= 1'b1;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !hw_reset_in_n);

  // both write channels taken together
  sequence wr_take;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  // read address taken
  sequence ar_take;
    s_arvalid && s_arready;
  endsequence

  chk_sleep_holds: assert property (
    power_saving && !wr_start |=> power_saving)
    else $error("power save left without a host write");
  chk_write_wakes: assert property (
    power_saving && wr_start |=> !power_saving)
    else $error("host write did not end power save");
  chk_no_ok_asleep: assert property (
    power_saving |-> !host_write_ok)
    else $error("write accepted while asleep");
  chk_ok_after_read: assert property (
    host_write_ok |-> rd_seen && wr_start)
    else $error("write accepted before a read");
  chk_pin_reset: assert property (disable iff (1'b0)
    !hw_reset_in_n |-> !power_saving && !irq && !s_bvalid && !s_rvalid)
    else $error("state not cleared by reset pin");
  chk_bus_reset: assert property (disable iff (1'b0)
    !aresetn [*3] |-> !power_saving && !irq && !s_bvalid)
    else $error("state not cleared by bus reset");
  chk_od_release: assert property (
    !wake_indicator_oe |-> wake_indicator_o)
    else $error("released wake pin not high");
  chk_b_answer: assert property (
    wr_take |-> ##[1:2] s_bvalid)
    else $error("write response late");
  chk_r_answer: assert property (
    ar_take |=> s_rvalid)
    else $error("read response late");
  chk_b_stable: assert property (
    s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped");
endmodule : rwc_reset_wake_monitor

bind rwc_reset_wake rwc_reset_wake_monitor u_rwc_reset_wake_monitor (.*);

`default_nettype wire

// ---- verilog/rwc_edge_det.sv ----
`timescale 1ns/1ps
`default_nettype none

module rwc_edge_det
  import rwc_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             rst_n,
  // qualified cycle levels
  input  wire logic [STB_W-1:0] level,
  // one-cycle start pulses
  output logic      [STB_W-1:0] start
);

  logic [STB_W-1:0] prev;       // level one cycle ago
  logic [STB_W-1:0] next_prev;  // next value of prev

  // one detector per strobe
  for (genvar i = 0; i < STB_W; i++) begin : g_det
    always_comb begin
      next_prev[i] = level[i];
      start[i]     = level[i] & ~prev[i];
    end
  end

  // level history
  always_ff @(posedge aclk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end

endmodule : rwc_edge_det

`default_nettype wire

// ---- verilog/rwc_pkg.sv ----
package rwc_pkg;

  // register bus geometry
  localparam int unsigned AXI_AW       = 8;
  localparam int unsigned AXI_DW       = 32;
  localparam int unsigned AXI_SW       = AXI_DW / 8;

  // register byte addresses
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATE     = 8'h04;
  localparam logic [7:0] REG_EVT_STAT  = 8'h08;
  localparam logic [7:0] REG_EVT_MASK  = 8'h0c;

  // control register field positions
  localparam int unsigned CTRL_SLEEP   = 0;   // write 1: enter power save
  localparam int unsigned CTRL_SOFT_RESET_BIT    = 1;   // write 1: soft reset
  localparam int unsigned CTRL_WEN     = 2;   // wake indicator enable
  localparam int unsigned CTRL_WPOL    = 3;   // 1: indicator active high
  localparam int unsigned CTRL_WPP     = 4;   // 1: push-pull, 0: open drain
  localparam int unsigned CTRL_W       = 5;

  // event status / mask bit positions
  localparam int unsigned EV_WAKE      = 0;   // wake event detected
  localparam int unsigned EV_WOKE      = 1;   // host write woke device
  localparam int unsigned EV_REFUSED   = 2;   // write ignored before read
  localparam int unsigned EV_W         = 3;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [EV_W-1:0]   EV_RST   = 3'h0;
  localparam logic [1:0]        SYNC_RST = 2'h0;
  localparam logic [1:0]        SYNC_ONE = 2'h1;

  // bus responses
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // host strobe positions in the edge detector
  localparam int unsigned STB_RD       = 0;
  localparam int unsigned STB_WR       = 1;
  localparam int unsigned STB_W        = 2;

  // power / access state
  typedef enum logic [2:0] {
    ST_NEED_READ = 3'h1,
    ST_ACTIVE    = 3'h2,
    ST_SLEEP     = 3'h4
  } rwc_state_e;

  // true when a word address matches a register offset
  function automatic logic rwc_hit(input logic [AXI_AW-1:0] a,
                                   input logic [AXI_AW-1:0] off);
    rwc_hit = (a[AXI_AW-1:2] == off[AXI_AW-1:2]);
  endfunction : rwc_hit

endpackage : rwc_pkg

// ---- verilog/rwc_reset_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module rwc_reset_sync
  import rwc_pkg::*;
(
  // clock and reset sources
  input  wire logic aclk,
  input  wire logic hw_reset_in_n,
  input  wire logic sync_clear,
  // combined reset
  output logic      rst_n
);

  logic [1:0] stage;       // release pipeline
  logic [1:0] next_stage;  // next value of the pipeline

  // bus reset and soft reset act on the clock; ones shift in afterwards
  always_comb begin
    if (sync_clear) begin
      next_stage = SYNC_RST;
    end else begin
      next_stage = {stage[0], SYNC_ONE[0]};
    end
  end

  // pin reset clears at once, release follows two clock edges
  always_ff @(posedge aclk or negedge hw_reset_in_n) begin
    if (!hw_reset_in_n) begin
      stage <= SYNC_RST;
    end else begin
      stage <= next_stage;
    end
  end

  // only the second stage leaves this module
  assign rst_n = stage[1];

endmodule : rwc_reset_sync

`default_nettype wire

// ---- verilog/rwc_reset_wake.sv ----
// Behaviour
// - reset pin clears all logic and registers
// - writes ignored until first read after reset/wake
// - enabled wake indicator asserts on wake event
// - indicator polarity and driver type configurable
// - wake event never ends power save itself
// - power save ends only on host write cycle
// - any write wakes, whatever address or data
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module rwc_reset_wake
  import rwc_pkg::*;
(
  // clock and bus reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // reset pin
  input  wire logic              hw_reset_in_n,
  // host bus strobes
  input  wire logic              chip_sel_low,
  input  wire logic              write_strobe_low,
  input  wire logic              read_strobe_low,
  // wake event from detection logic
  input  wire logic              wake_event_in,
  // host access results
  output logic                   host_write_ok,
  output logic                   host_read_seen,
  output logic                   power_saving,
  // wake indicator pin
  output logic                   wake_indicator_o,
  output logic                   wake_indicator_oe,
  // interrupt
  output logic                   irq,
  // axi4-lite write address
  input  wire logic [AXI_AW-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  // axi4-lite write data
  input  wire logic [AXI_DW-1:0] s_wdata,
  input  wire logic [AXI_SW-1:0] s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  // axi4-lite write response
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // axi4-lite read address
  input  wire logic [AXI_AW-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  // axi4-lite read data
  output logic [AXI_DW-1:0]      s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready
);

  // internal reset and strobe pulses
  logic             rst_n;        // combined, released on the clock
  logic             soft_rst;     // soft reset pulse after its response
  logic [STB_W-1:0] stb_level;    // qualified host cycles
  logic [STB_W-1:0] stb_start;    // first cycle of each host cycle

  // access state
  rwc_state_e state;
  rwc_state_e next_state;

  // bus slave holding registers
  logic              aw_have, next_aw_have;
  logic [AXI_AW-1:0] aw_addr, next_aw_addr;
  logic              w_have,  next_w_have;
  logic [AXI_DW-1:0] w_data,  next_w_data;
  logic [AXI_SW-1:0] w_strb,  next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [1:0]        next_rresp;
  logic [AXI_DW-1:0] next_rdata;

  // software registers
  logic [CTRL_W-1:0] ctrl, next_ctrl;      // persistent control bits
  logic [EV_W-1:0]   ev_stat, next_ev_stat; // sticky events
  logic [EV_W-1:0]   ev_mask, next_ev_mask; // interrupt mask
  logic              soft_reset_bit_pend, next_soft_reset_bit_pend;

  // decoded actions
  logic            wr_fire;    // register write performed this cycle
  logic            sleep_go;   // software asks for power save
  logic [EV_W-1:0] ev_set;     // hardware events this cycle
  logic [EV_W-1:0] ev_clr;     // write-one-to-clear mask
  logic            wake_act;   // indicator logically asserted

  // pin reset plus bus or soft reset, released together
  rwc_reset_sync u_rst (
    .aclk          (aclk),
    .hw_reset_in_n (hw_reset_in_n),
    .sync_clear    (!aresetn || soft_rst),
    .rst_n         (rst_n)
  );

  // host strobes qualified by chip select
  assign stb_level[STB_RD] = !chip_sel_low && !read_strobe_low;
  assign stb_level[STB_WR] = !chip_sel_low && !write_strobe_low;

  rwc_edge_det u_edge (
    .aclk  (aclk),
    .rst_n (rst_n),
    .level (stb_level),
    .start (stb_start)
  );

  // access state: read unlocks writes, write ends power save
  always_comb begin
    next_state     = state;
    host_write_ok  = 1'b0;
    host_read_seen = stb_start[STB_RD];
    ev_set         = EV_RST;
    ev_set[EV_WAKE] = wake_event_in;
    unique case (state)
      // writes are dropped until the host reads once
      ST_NEED_READ: begin
        ev_set[EV_REFUSED] = stb_start[STB_WR];
        if (stb_start[STB_RD]) begin
          next_state = ST_ACTIVE;
        end
      end
      // normal operation
      ST_ACTIVE: begin
        host_write_ok = stb_start[STB_WR];
        if (sleep_go) begin
          next_state = ST_SLEEP;
        end
      end
      // only a write cycle leaves, address and data ignored
      ST_SLEEP: begin
        if (stb_start[STB_WR]) begin
          next_state      = ST_NEED_READ;
          ev_set[EV_WOKE] = 1'b1;
        end
      end
    endcase
  end

  // power save flag follows the state
  assign power_saving = (state == ST_SLEEP);

  // state register
  always_ff @(posedge aclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_NEED_READ;
    end else begin
      state <= next_state;
    end
  end

  // write channel: address and data taken in any order
  always_comb begin
    next_aw_have = aw_have;
    next_aw_addr = aw_addr;
    next_w_have  = w_have;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_bvalid;
    next_bresp   = s_bresp;
    s_awready    = !aw_have && !s_bvalid;
    s_wready     = !w_have && !s_bvalid;
    wr_fire      = aw_have && w_have && !s_bvalid;
    if (s_awvalid && s_awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      next_w_have = 1'b1;
      next_w_data = s_wdata;
      next_w_strb = s_wstrb;
    end
    // both halves held: perform and answer
    if (wr_fire) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      if (rwc_hit(aw_addr, REG_CTRL) || rwc_hit(aw_addr, REG_STATE) ||
          rwc_hit(aw_addr, REG_EVT_STAT) ||
          rwc_hit(aw_addr, REG_EVT_MASK)) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;   // unmapped
      end
    end else if (s_bvalid && s_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // register file updates
  always_comb begin
    next_ctrl      = ctrl;
    next_ev_mask   = ev_mask;
    next_soft_reset_bit_pend = soft_reset_bit_pend;
    sleep_go       = 1'b0;
    ev_clr         = EV_RST;
    if (wr_fire && w_strb[0]) begin
      // control: sleep and soft reset are actions, rest persist
      if (rwc_hit(aw_addr, REG_CTRL)) begin
        next_ctrl      = w_data[CTRL_W-1:0];
        next_ctrl[CTRL_SLEEP] = 1'b0;
        next_ctrl[CTRL_SOFT_RESET_BIT]  = 1'b0;
        sleep_go       = w_data[CTRL_SLEEP];
        next_soft_reset_bit_pend = soft_reset_bit_pend || w_data[CTRL_SOFT_RESET_BIT];
      end
      // event status: write one to clear
      if (rwc_hit(aw_addr, REG_EVT_STAT)) begin
        ev_clr = w_data[EV_W-1:0];
      end
      // event mask
      if (rwc_hit(aw_addr, REG_EVT_MASK)) begin
        next_ev_mask = w_data[EV_W-1:0];
      end
    end
    // a new event wins over a clear in the same cycle
    next_ev_stat = (ev_stat & ~ev_clr) | ev_set;
  end

  // soft reset fires once its write has been answered
  assign soft_rst = soft_reset_bit_pend && s_bvalid && s_bready;

  // read channel: one cycle to answer
  always_comb begin
    next_rvalid = s_rvalid;
    next_rresp  = s_rresp;
    next_rdata  = s_rdata;
    s_arready   = !s_rvalid;
    if (s_arvalid && s_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      if (rwc_hit(s_araddr, REG_CTRL)) begin
        next_rdata[CTRL_W-1:0] = ctrl;
      end else if (rwc_hit(s_araddr, REG_STATE)) begin
        next_rdata[$bits(state)-1:0] = state;
      end else if (rwc_hit(s_araddr, REG_EVT_STAT)) begin
        next_rdata[EV_W-1:0] = ev_stat;
      end else if (rwc_hit(s_araddr, REG_EVT_MASK)) begin
        next_rdata[EV_W-1:0] = ev_mask;
      end else begin
        next_rresp = RESP_SLVERR;   // unmapped
      end
    end else if (s_rvalid && s_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // bus and register flops, all cleared by any reset
  always_ff @(posedge aclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have   <= 1'b0;
      aw_addr   <= '0;
      w_have    <= 1'b0;
      w_data    <= '0;
      w_strb    <= '0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
      s_rvalid  <= 1'b0;
      s_rresp   <= RESP_OKAY;
      s_rdata   <= '0;
      ctrl      <= CTRL_RST;
      ev_stat   <= EV_RST;
      ev_mask   <= EV_RST;
      soft_reset_bit_pend <= 1'b0;
    end else begin
      aw_have   <= next_aw_have;
      aw_addr   <= next_aw_addr;
      w_have    <= next_w_have;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      s_bvalid  <= next_bvalid;
      s_bresp   <= next_bresp;
      s_rvalid  <= next_rvalid;
      s_rresp   <= next_rresp;
      s_rdata   <= next_rdata;
      ctrl      <= next_ctrl;
      ev_stat   <= next_ev_stat;
      ev_mask   <= next_ev_mask;
      soft_reset_bit_pend <= next_soft_reset_bit_pend;
    end
  end

  // level interrupt from unmasked sticky events
  assign irq = |(ev_stat & ev_mask);

  // indicator asserted while enabled and a wake event is pending
  assign wake_act = ctrl[CTRL_WEN] && ev_stat[EV_WAKE];

  // polarity and driver: open drain drives only its low level
  always_comb begin
    wake_indicator_o  = ctrl[CTRL_WPOL] ? wake_act : !wake_act;
    wake_indicator_oe = ctrl[CTRL_WPP] || !wake_indicator_o;
  end

endmodule : rwc_reset_wake

`default_nettype wire
